// ---- pkg/asrc_pkg.sv ----
// constants, types and encodings shared by the rate converter files
package asrc_pkg;
    localparam int SAMPLE_W   = 16;
    localparam int OUT_W      = 24;
    localparam int PER_W      = 16;
    localparam int FRAC_W     = 8;
    localparam int WORD_W     = 2 * OUT_W;
    localparam int IN_WORD_W  = 2 * SAMPLE_W;
    localparam int WIDE_W     = 26;
    localparam int BUF_DEPTH  = 2;

    // mute is held at least this many reference clock cycles after reset
    localparam logic [7:0] MUTE_MIN_CYCLES = 8'h80;

    // both period estimates start equal, so the ratio starts at 1:1
    localparam logic [PER_W-1:0] PERIOD_INIT = 16'h1000;
    localparam logic [PER_W-1:0] PERIOD_MAX  = 16'hffff;
    localparam logic [PER_W-1:0] PERIOD_ONE  = 16'h0001;

    // tracking gain 1/4, settle window 1/16, ratio guard band 1/32
    localparam int TRACK_SHIFT = 2;
    localparam int SETTLE_SHIFT = 4;
    localparam int LIMIT_SHIFT = 5;
    localparam logic [1:0] SETTLE_COUNT = 2'h3;
    localparam logic [1:0] SEEN_FULL    = 2'h2;

    localparam logic [2:0] DIV_LAST = 3'h7;

    localparam logic [OUT_W-1:0] FULL_POS = 24'h7fffff;
    localparam logic [OUT_W-1:0] FULL_NEG = 24'h800000;

    typedef enum logic [2:0]
    {
        ST_WAIT = 3'b001,
        ST_DIV  = 3'b010,
        ST_PUSH = 3'b100
    } conv_state_t;
endpackage

// ---- pkg/word_stream_if.sv ----
// valid/ready stream of stereo output words between converter and buffer
interface word_stream_if;
    logic                       valid;
    logic                       ready;
    logic [asrc_pkg::WORD_W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ---- verilog/sample_buffer.sv ----
// two-entry output word buffer with registered head
module sample_buffer
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    // fill and drain sides
    word_stream_if.snk wr,
    word_stream_if.src rd
);
    import asrc_pkg::*;

    typedef struct packed
    {
        logic [WORD_W-1:0] head;
        logic [WORD_W-1:0] tail;
        logic [1:0]        count;
    } buf_state_t;

    buf_state_t st_reg;
    buf_state_t st_next;
    logic       push;
    logic       pop;

    // full refuses the writer, which stalls the converter
    assign wr.ready = (st_reg.count != 2'(BUF_DEPTH));
    assign rd.valid = (st_reg.count != 2'h0);
    assign rd.data  = st_reg.head;
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    always_comb
    begin
        st_next = st_reg;
        if (pop)
        begin
            if (st_reg.count == 2'(BUF_DEPTH))
                st_next.head = st_reg.tail;
            else if (push)
                st_next.head = wr.data;
        end
        else if (push)
        begin
            if (st_reg.count == 2'h0)
                st_next.head = wr.data;
            else
                st_next.tail = wr.data;
        end
        if (push && !pop)
            st_next.count = st_reg.count + 2'h1;
        else if (pop && !push)
            st_next.count = st_reg.count - 2'h1;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
endmodule

// ---- verilog/asrc_ratio_mute_sync.sv ----
// stereo rate converter core: clock tracking, interpolation, clipping and mute
// Function
// - same clocks give identical output streams
// - overrange interpolated samples clip to full scale
// - mute before ratio reaches 1:2 or 2:1
// - mute silences left and right together
// - near-equal or tied sample clocks convert cleanly
// - mute high 128 cycles and while settling
// - reset keeps pipeline, ratio restarts at 1:1
module asrc_ratio_mute_sync
(
    // clock and reset
    input  wire logic                              REF_CLK_I,
    input  wire logic                              ARST_N_I,
    // sample clocks
    input  wire logic                              LR_IN_I,
    input  wire logic                              LR_OUT_I,
    // input samples, taken at the rising input sample clock
    input  wire logic [asrc_pkg::SAMPLE_W-1:0]     IN_LEFT_I,
    input  wire logic [asrc_pkg::SAMPLE_W-1:0]     IN_RIGHT_I,
    // output samples
    output logic      [asrc_pkg::OUT_W-1:0]        OUT_LEFT_O,
    output logic      [asrc_pkg::OUT_W-1:0]        OUT_RIGHT_O,
    output logic                                   OUT_VALID_O,
    input  wire logic                              OUT_READY_I,
    // status
    output logic                                   MUTE_O
);
    import asrc_pkg::*;

    typedef struct packed
    {
        logic                 lr_in_m;
        logic                 lr_in_s;
        logic                 lr_in_d;
        logic                 lr_out_m;
        logic                 lr_out_s;
        logic                 lr_out_d;
        logic [IN_WORD_W-1:0] din_m;
        logic [IN_WORD_W-1:0] din_s;
        logic [PER_W-1:0]     cnt_in;
        logic [PER_W-1:0]     cnt_out;
        logic [PER_W-1:0]     est_in;
        logic [PER_W-1:0]     est_out;
        logic                 close_in;
        logic                 close_out;
        logic [1:0]           settle_cnt;
        logic [1:0]           seen;
        logic [7:0]           mute_cnt;
        logic                 mute_reg;
        conv_state_t          state;
        logic [PER_W:0]       rem;
        logic [FRAC_W-1:0]    quo;
        logic [2:0]           bit_cnt;
    } core_state_t;

    typedef struct packed
    {
        logic [SAMPLE_W-1:0] l0;
        logic [SAMPLE_W-1:0] l1;
        logic [SAMPLE_W-1:0] r0;
        logic [SAMPLE_W-1:0] r1;
    } hist_t;

    core_state_t st_reg;
    core_state_t st_next;
    hist_t       hist_reg;
    logic        in_edge;
    logic        out_edge;
    logic        ratio_bad;
    logic [WIDE_W-1:0] wide_l;
    logic [WIDE_W-1:0] wide_r;

    word_stream_if push_if ();
    word_stream_if pop_if ();

    // x1 + (x1 - x0) * frac, scaled to the 24-bit output grid
    function automatic logic [WIDE_W-1:0] mix(input logic [SAMPLE_W-1:0] x0,
                                               input logic [SAMPLE_W-1:0] x1,
                                               input logic [FRAC_W-1:0]   f);
        logic signed [WIDE_W-1:0] base;
        logic signed [WIDE_W-1:0] diff;
        logic signed [WIDE_W-1:0] prod;
        base = {{2{x1[SAMPLE_W-1]}}, x1, 8'h00};
        diff = WIDE_W'($signed({x1[SAMPLE_W-1], x1}) - $signed({x0[SAMPLE_W-1], x0}));
        prod = diff * $signed({1'b0, f});
        return base + prod;
    endfunction

    function automatic logic [OUT_W-1:0] clip(input logic [WIDE_W-1:0] w);
        if ($signed(w) > $signed({2'b00, FULL_POS}))
            return FULL_POS;
        else if ($signed(w) < $signed({2'b11, FULL_NEG}))
            return FULL_NEG;
        else
            return w[OUT_W-1:0];
    endfunction

    // true when twice a is at most b plus a small band above b
    function automatic logic near_limit(input logic [PER_W-1:0] a, input logic [PER_W-1:0] b);
        logic [PER_W:0] lim;
        lim = {1'b0, b} + (PER_W + 1)'(b >> LIMIT_SHIFT);
        return {a, 1'b0} <= lim;
    endfunction

    // rising steps round up, falling ones round down, so the estimate lands on the measured period;
    // truncating both ways stalls a few counts short and hides a 2:1 ratio from the guard band
    function automatic logic [PER_W-1:0] track(input logic [PER_W-1:0] est, input logic [PER_W-1:0] meas);
        logic signed [PER_W+1:0] d;
        logic signed [PER_W+1:0] bias;
        logic signed [PER_W+1:0] step;
        d    = $signed({2'b00, meas}) - $signed({2'b00, est});
        bias = (PER_W + 2)'((1 << TRACK_SHIFT) - 1);
        if (d > bias - bias)
            step = (d + bias) >>> TRACK_SHIFT;
        else
            step = d >>> TRACK_SHIFT;
        return PER_W'($signed({2'b00, est}) + step);
    endfunction

    function automatic logic close(input logic [PER_W-1:0] est, input logic [PER_W-1:0] meas);
        logic [PER_W-1:0] d;
        d = (meas > est) ? meas - est : est - meas;
        return d <= (est >> SETTLE_SHIFT);
    endfunction

    // edges seen only after two synchroniser stages
    assign in_edge   = st_reg.lr_in_s && !st_reg.lr_in_d;
    assign out_edge  = st_reg.lr_out_s && !st_reg.lr_out_d;
    assign ratio_bad = near_limit(st_reg.est_in, st_reg.est_out)
                    || near_limit(st_reg.est_out, st_reg.est_in);
    assign wide_l    = mix(hist_reg.l0, hist_reg.l1, st_reg.quo);
    assign wide_r    = mix(hist_reg.r0, hist_reg.r1, st_reg.quo);

    assign push_if.valid = (st_reg.state == ST_PUSH);
    // muting blanks both channels of the same word
    assign push_if.data  = st_reg.mute_reg ? '0 : {clip(wide_l), clip(wide_r)};
    assign pop_if.ready  = OUT_READY_I;
    assign OUT_VALID_O   = pop_if.valid;
    assign OUT_LEFT_O    = pop_if.data[WORD_W-1:OUT_W];
    assign OUT_RIGHT_O   = pop_if.data[OUT_W-1:0];
    assign MUTE_O        = st_reg.mute_reg;

    sample_buffer u_buffer
    (
        .clk_i    (REF_CLK_I),
        .arst_n_i (ARST_N_I),
        .wr       (push_if.snk),
        .rd       (pop_if.src)
    );

    always_comb
    begin
        logic [PER_W:0] rem2;
        rem2    = '0;
        st_next = st_reg;
        st_next.lr_in_m  = LR_IN_I;
        st_next.lr_in_s  = st_reg.lr_in_m;
        st_next.lr_in_d  = st_reg.lr_in_s;
        st_next.lr_out_m = LR_OUT_I;
        st_next.lr_out_s = st_reg.lr_out_m;
        st_next.lr_out_d = st_reg.lr_out_s;
        st_next.din_m    = {IN_LEFT_I, IN_RIGHT_I};
        st_next.din_s    = st_reg.din_m;

        if (in_edge)
        begin
            st_next.cnt_in   = '0;
            st_next.est_in   = track(st_reg.est_in, st_reg.cnt_in);
            st_next.close_in = close(st_reg.est_in, st_reg.cnt_in);
            if (st_reg.seen != SEEN_FULL)
                st_next.seen = st_reg.seen + 2'h1;
            // settled only after several periods inside the window on both sides
            if (st_reg.close_in && st_reg.close_out)
                st_next.settle_cnt = (st_reg.settle_cnt == SETTLE_COUNT) ? SETTLE_COUNT
                                                                         : st_reg.settle_cnt + 2'h1;
            else
                st_next.settle_cnt = '0;
        end
        else if (st_reg.cnt_in != PERIOD_MAX)
            st_next.cnt_in = st_reg.cnt_in + PERIOD_ONE;

        if (out_edge)
        begin
            st_next.cnt_out   = '0;
            st_next.est_out   = track(st_reg.est_out, st_reg.cnt_out);
            st_next.close_out = close(st_reg.est_out, st_reg.cnt_out);
        end
        else if (st_reg.cnt_out != PERIOD_MAX)
            st_next.cnt_out = st_reg.cnt_out + PERIOD_ONE;

        if (st_reg.mute_cnt != 8'h00)
            st_next.mute_cnt = st_reg.mute_cnt - 8'h01;
        st_next.mute_reg = (st_reg.mute_cnt != 8'h00)
                        || (st_reg.settle_cnt != SETTLE_COUNT)
                        || (st_reg.seen != SEEN_FULL)
                        || ratio_bad;

        case (st_reg.state)
            ST_WAIT:
            begin
                if (out_edge)
                begin
                    // tied clocks: the new input sample is the phase origin
                    if (in_edge)
                        st_next.rem = '0;
                    else if (st_reg.cnt_in >= st_reg.est_in)
                        st_next.rem = {1'b0, st_reg.est_in - PERIOD_ONE};
                    else
                        st_next.rem = {1'b0, st_reg.cnt_in};
                    st_next.quo     = '0;
                    st_next.bit_cnt = '0;
                    st_next.state   = ST_DIV;
                end
            end
            ST_DIV:
            begin
                // fixed eight-step divide keeps latency identical across parts
                rem2 = {st_reg.rem[PER_W-1:0], 1'b0};
                if (rem2 >= {1'b0, st_reg.est_in})
                begin
                    st_next.rem = rem2 - {1'b0, st_reg.est_in};
                    st_next.quo = {st_reg.quo[FRAC_W-2:0], 1'b1};
                end
                else
                begin
                    st_next.rem = rem2;
                    st_next.quo = {st_reg.quo[FRAC_W-2:0], 1'b0};
                end
                st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
                if (st_reg.bit_cnt == DIV_LAST)
                    st_next.state = ST_PUSH;
            end
            ST_PUSH:
            begin
                // a full buffer holds the word here; output ticks meanwhile are skipped
                if (push_if.ready)
                    st_next.state = ST_WAIT;
            end
            default:
                st_next.state = ST_WAIT;
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            st_reg          <= '0;
            st_reg.est_in   <= PERIOD_INIT;
            st_reg.est_out  <= PERIOD_INIT;
            st_reg.mute_cnt <= MUTE_MIN_CYCLES;
            st_reg.mute_reg <= 1'b1;
            st_reg.state    <= ST_WAIT;
        end
        else
            st_reg <= st_next;
    end

    // sample history has no reset so a reset leaves the pipeline intact
    always_ff @(posedge REF_CLK_I)
    begin
        if (in_edge)
            hist_reg <= {hist_reg.l1, st_reg.din_s[IN_WORD_W-1:SAMPLE_W],
                         hist_reg.r1, st_reg.din_s[SAMPLE_W-1:0]};
    end

    // cycles since reset release, read only by the checks below
    logic [7:0] since_rst;
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            since_rst <= 8'h00;
        else if (since_rst != 8'hff)
            since_rst <= since_rst + 8'h01;
    end

    AST_MUTE_HOLD: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (since_rst <= MUTE_MIN_CYCLES) |-> MUTE_O)
        else $error("mute dropped within the minimum hold after reset");
    AST_MUTE_SETTLE: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (st_reg.settle_cnt != SETTLE_COUNT) |=> MUTE_O)
        else $error("mute low while tracking loop not settled");
    AST_LIMIT_MUTE: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        ratio_bad |=> MUTE_O)
        else $error("ratio near 1:2 or 2:1 without mute");
    AST_BOTH_MUTED: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (push_if.valid && st_reg.mute_reg) |-> (push_if.data == '0))
        else $error("muted word carries nonzero data on a channel");
    AST_CLIP_HIGH: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (push_if.valid && !st_reg.mute_reg && $signed(wide_l) > $signed({2'b00, FULL_POS}))
        |-> (push_if.data[WORD_W-1:OUT_W] == FULL_POS))
        else $error("left overrange not clipped to positive full scale");
    AST_CLIP_LOW: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (push_if.valid && !st_reg.mute_reg && $signed(wide_r) < $signed({2'b11, FULL_NEG}))
        |-> (push_if.data[OUT_W-1:0] == FULL_NEG))
        else $error("right overrange not clipped to negative full scale");
    AST_RATIO_INIT: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (since_rst < 8'h03) |-> (st_reg.est_in == PERIOD_INIT && st_reg.est_out == PERIOD_INIT))
        else $error("ratio estimate did not restart at 1:1");
    AST_TIED_PHASE: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (in_edge && out_edge && st_reg.state == ST_WAIT) |=> (st_reg.rem == '0))
        else $error("tied sample clocks gave a nonzero phase");
    AST_FIXED_LATENCY: assert property (@(posedge REF_CLK_I) disable iff (!ARST_N_I)
        (out_edge && st_reg.state == ST_WAIT) |=> (st_reg.state == ST_DIV) [*8] ##1 (st_reg.state == ST_PUSH))
        else $error("conversion latency not fixed at eight divide steps");
endmodule

// ---- testbench/asrc_partner.sv ----
// sample clock source, input sample feed and output word sink around the converter
module asrc_partner
    import asrc_pkg::*;
(
    // bench clock, paces the sink only
    input  wire logic                clk_i,
    // sample clocks and input samples
    output logic                     lr_in_o,
    output logic                     lr_out_o,
    output logic [SAMPLE_W-1:0]      in_left_o,
    output logic [SAMPLE_W-1:0]      in_right_o,
    // sink handshake
    output logic                     ready_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // output clock: 0 tied to input, 1 input delayed by a quarter period, 2 free running
    int                   sel      = 0;
    real                  out_half = 80.0;
    logic                 alt      = 1'b0;
    logic                 stall    = 1'b0;
    logic [SAMPLE_W-1:0]  k_left   = 16'h1234;
    logic [SAMPLE_W-1:0]  k_right  = 16'hc001;
    logic                 lr_shift = 1'b0;
    logic                 lr_own   = 1'b0;

    // sample clocks only: no bit clock is modelled, a 64x one would be the choice
    initial
    begin
        lr_in_o    = 1'b0;
        in_left_o  = k_left;
        in_right_o = k_right;
        ready_o    = 1'b1;
        #3.3;
        forever
            #80.0 lr_in_o = ~lr_in_o;
    end

    // odd start offset keeps the free clock unrelated in phase to the reference
    initial
    begin
        #17.9;
        forever
            #(out_half) lr_own = ~lr_own;
    end

    always @(lr_in_o)
        lr_shift <= #40.0 lr_in_o;

    // tied or nearly synchronous clocks are legal input
    assign lr_out_o = (sel == 0) ? lr_in_o : (sel == 1) ? lr_shift : lr_own;

    // new data on the falling edge, so it is steady around the rising one
    always @(negedge lr_in_o)
    begin
        in_left_o  <= alt ? ((in_left_o == 16'h7fff) ? 16'h8000 : 16'h7fff) : k_left;
        in_right_o <= alt ? ((in_left_o == 16'h7fff) ? 16'h7fff : 16'h8000) : k_right;
    end

    always @(posedge clk_i)
        ready_o <= #1 ~stall;
endmodule

// ---- testbench/tb.sv ----
// self-checking bench: reset, tied and near clocks, buffer stall, clipping, ratio mute, lockstep
`define CHK(got, exp, msg) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("Error %0t: %s", $time, msg); \
        end \
    end

module tb
    import asrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic                ref_clk = 1'b0;
    logic                arst_n  = 1'b0;
    logic                lr_in;
    logic                lr_out;
    logic                ready;
    logic [SAMPLE_W-1:0] in_l;
    logic [SAMPLE_W-1:0] in_r;
    logic [OUT_W-1:0]    out_l [2];
    logic [OUT_W-1:0]    out_r [2];
    logic                valid [2];
    logic                mute  [2];
    logic [WORD_W-1:0]   exp_k;
    int                  num_errors = 0;
    int                  cmp_count  = 0;

    always #2.5 ref_clk = ~ref_clk;

    asrc_partner u_asrc_partner
    (
        .clk_i      (ref_clk),
        .lr_in_o    (lr_in),
        .lr_out_o   (lr_out),
        .in_left_o  (in_l),
        .in_right_o (in_r),
        .ready_o    (ready)
    );

    for (genvar gi = 0; gi < 2; gi++)
    begin : g_conv
        // one reset and one reference clock shared by both cores
        asrc_ratio_mute_sync u_asrc_ratio_mute_sync
        (
            .REF_CLK_I   (ref_clk),
            .ARST_N_I    (arst_n),
            .LR_IN_I     (lr_in),
            .LR_OUT_I    (lr_out),
            .IN_LEFT_I   (in_l),
            .IN_RIGHT_I  (in_r),
            .OUT_LEFT_O  (out_l[gi]),
            .OUT_RIGHT_O (out_r[gi]),
            .OUT_VALID_O (valid[gi]),
            .OUT_READY_I (ready),
            .MUTE_O      (mute[gi])
        );
    end

    always @(negedge ref_clk)
        if (arst_n)
        begin
            `CHK({out_l[1], out_r[1], valid[1], mute[1]}, {out_l[0], out_r[0], valid[0], mute[0]}, "cores differ")
        end

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic do_reset();
        cycles(1);
        arst_n = 1'b0;
        cycles(16);
        `CHK({mute[0], valid[0], out_l[0], out_r[0]}, {1'b1, 1'b0, 48'h0}, "reset state")
        arst_n = 1'b1;
        repeat (128)
        begin
            @(negedge ref_clk);
            `CHK(mute[0], 1'b1, "mute dropped early")
        end
    endtask

    task automatic wait_mute(input logic lvl);
        int n;
        n = 0;
        while (mute[0] !== lvl && n < 4000)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 4000)
        begin
            num_errors++;
            $display("Error %0t: mute level not reached", $time);
            tally_and_finish();
        end
    endtask

    // sat set: each word must be a clipped full-scale pair, else it must equal ew
    task automatic pop_words(input int n, input logic sat, input logic [WORD_W-1:0] ew);
        int t;
        repeat (n)
        begin
            t = 0;
            do
            begin
                @(negedge ref_clk);
                t++;
            end
            while (!(valid[0] === 1'b1 && ready === 1'b1) && t < 800);
            if (t >= 800)
            begin
                num_errors++;
                $display("Error %0t: no output word", $time);
                tally_and_finish();
            end
            if (sat)
            begin
                `CHK(out_l[0] === FULL_POS || out_l[0] === FULL_NEG, 1'b1, "left not clipped")
                `CHK(out_r[0], ~out_l[0], "right not clipped")
            end
            else
                `CHK({out_l[0], out_r[0]}, ew, "word value")
        end
    endtask

    task automatic sc_tied();
        u_asrc_partner.sel = 0;
        wait_mute(1'b0);
        pop_words(4, 1'b0, exp_k);
    endtask

    task automatic sc_stall();
        u_asrc_partner.stall = 1'b1;
        cycles(400);
        `CHK({valid[0], out_l[0], out_r[0]}, {1'b1, exp_k}, "held word")
        cycles(100);
        `CHK({valid[0], out_l[0], out_r[0]}, {1'b1, exp_k}, "word moved in stall")
        u_asrc_partner.stall = 1'b0;
        pop_words(4, 1'b0, exp_k);
    endtask

    task automatic sc_near();
        u_asrc_partner.out_half = 82.0;
        u_asrc_partner.sel = 2;
        cycles(300);
        wait_mute(1'b0);
        pop_words(4, 1'b0, exp_k);
    endtask

    task automatic sc_clip();
        u_asrc_partner.sel = 1;
        u_asrc_partner.alt = 1'b1;
        cycles(300);
        wait_mute(1'b0);
        pop_words(6, 1'b1, '0);
        u_asrc_partner.alt = 1'b0;
    endtask

    task automatic sc_ratio();
        real halves [2] = '{160.0, 40.0};
        foreach (halves[i])
        begin
            u_asrc_partner.out_half = 80.0;
            u_asrc_partner.sel = 2;
            wait_mute(1'b0);
            u_asrc_partner.out_half = halves[i];
            wait_mute(1'b1);
            cycles(300);
            pop_words(3, 1'b0, '0);
            `CHK(mute[0], 1'b1, "mute lost at ratio limit")
        end
    endtask

    task automatic sc_rereset();
        u_asrc_partner.sel = 0;
        do_reset();
        wait_mute(1'b0);
        pop_words(3, 1'b0, exp_k);
    endtask

    initial
    begin
        exp_k = {16'h1234, 8'h00, 16'hc001, 8'h00};
        do_reset();
        sc_tied();
        sc_stall();
        sc_near();
        sc_clip();
        sc_ratio();
        sc_rereset();
        tally_and_finish();
    end
endmodule
